// *** logic/dcp_builder.sv ***
// digitizer context packet builder top
// inputs are on clk_sys; words leave as a valid/ready stream of 32-bit words
`timescale 1ns/1ps
`default_nettype none
module dcp_builder (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// current digitizer settings
	input wire dcp_pkg::dcp_fields_type settings,
	input wire logic geo_enable,
	// time of day
	input wire dcp_pkg::dcp_time_type now,
	// software request for a full report with change bit clear, or the change packet when fields have changed
	input wire logic report_req,
	// word stream
	output logic word_valid,
	input wire logic word_ready,
	output logic [31:0] word_data,
	output logic word_last,
	// status
	output logic busy,
	output logic [3:0] pkt_count
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_HEADER = 7'b0000010,
		ST_PREFIX = 7'b0000100,
		ST_BW = 7'b0001000,
		ST_FO = 7'b0010000,
		ST_RL = 7'b0100000,
		ST_GEO = 7'b1000000
	} dcp_state_type;

	dcp_state_type state;
	dcp_pkg::dcp_fields_type last_sent;
	dcp_pkg::dcp_fields_type snap;
	dcp_pkg::dcp_time_type snap_time;
	dcp_pkg::dcp_present_type present;
	dcp_pkg::dcp_present_type next_present;
	logic snap_change;
	logic last_geo_en;
	logic report_pend;
	logic [3:0] idx;
	logic [15:0] size_words;
	logic [15:0] next_size;
	logic src_valid;
	logic src_ready;
	logic [31:0] src_data;
	logic src_last;
	logic changed;
	logic start;
	logic step;

	// ----------------------------------------
	// change detection and snapshot
	// ----------------------------------------
	always_comb begin
		next_present.bandwidth = settings.bandwidth != last_sent.bandwidth;
		next_present.freq_offset = settings.freq_offset != last_sent.freq_offset;
		next_present.ref_level = settings.ref_level != last_sent.ref_level;
		next_present.geo = geo_enable && (settings.geo != last_sent.geo || !last_geo_en);
		changed = |next_present;
		if (report_pend && !changed) begin
			// full report: every field present, geolocation only while geo_enable, change bit clear
			next_present.bandwidth = 1'b1;
			next_present.freq_offset = 1'b1;
			next_present.ref_level = 1'b1;
			next_present.geo = geo_enable;
		end
	end

	assign start = (state == ST_IDLE) && (changed || report_pend);

	dcp_size u_size (
		.present(next_present),
		.words(next_size)
	);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			report_pend <= 1'b0;
		end else if (report_req) begin
			report_pend <= 1'b1;
		end else if (start) begin
			report_pend <= 1'b0;
		end
	end

	// latch one consistent snapshot per packet
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			snap <= '0;
			snap_time <= '0;
			present <= '0;
			snap_change <= 1'b0;
			size_words <= '0;
			last_sent <= '0;
			last_geo_en <= 1'b0;
		end else if (start) begin
			snap <= settings;
			snap_time <= now;
			present <= next_present;
			snap_change <= changed;
			size_words <= next_size;
			last_sent <= settings;
			last_geo_en <= geo_enable;
		end
	end

	// ----------------------------------------
	// word sequencer
	// ----------------------------------------
	assign step = src_valid && src_ready;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			idx <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					idx <= '0;
					if (start) state <= ST_HEADER;
				end
				ST_HEADER: begin
					if (step) state <= ST_PREFIX;
				end
				ST_PREFIX: begin
					// stream id, seconds, two picosecond words, indicator
					if (step) begin
						idx <= 4'(idx + 4'h1);
						if (idx == 4'h4) begin
							idx <= '0;
							if (present.bandwidth) state <= ST_BW;
							else if (present.freq_offset) state <= ST_FO;
							else if (present.ref_level) state <= ST_RL;
							else if (present.geo) state <= ST_GEO;
							else state <= ST_IDLE;
						end
					end
				end
				ST_BW: begin
					if (step) begin
						idx <= 4'(idx + 4'h1);
						if (idx == 4'h1) begin
							idx <= '0;
							if (present.freq_offset) state <= ST_FO;
							else if (present.ref_level) state <= ST_RL;
							else if (present.geo) state <= ST_GEO;
							else state <= ST_IDLE;
						end
					end
				end
				ST_FO: begin
					if (step) begin
						idx <= 4'(idx + 4'h1);
						if (idx == 4'h1) begin
							idx <= '0;
							if (present.ref_level) state <= ST_RL;
							else if (present.geo) state <= ST_GEO;
							else state <= ST_IDLE;
						end
					end
				end
				ST_RL: begin
					if (step) begin
						if (present.geo) state <= ST_GEO;
						else state <= ST_IDLE;
					end
				end
				ST_GEO: begin
					if (step) begin
						idx <= 4'(idx + 4'h1);
						if (idx == dcp_pkg::GEO_LAST) begin
							idx <= '0;
							state <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pkt_count <= dcp_pkg::PKT_COUNT_RESET;
		end else if (step && state == ST_HEADER) begin
			pkt_count <= 4'(pkt_count + 4'h1);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= (state != ST_IDLE) || start;
		end
	end

	// ----------------------------------------
	// word contents
	// ----------------------------------------
	always_comb begin
		src_valid = state != ST_IDLE;
		src_data = '0;
		src_last = 1'b0;
		unique case (state)
			ST_IDLE: src_data = '0;
			ST_HEADER: begin
				src_data = {dcp_pkg::PKT_TYPE_CONTEXT, dcp_pkg::CLASS_FLAG,
					dcp_pkg::RESERVED_BITS, dcp_pkg::TS_MODE,
					dcp_pkg::TS_INT_UTC, dcp_pkg::TS_FRAC_PS,
					pkt_count, size_words};
			end
			ST_PREFIX: begin
				unique case (idx)
					4'h0: src_data = dcp_pkg::STREAM_ID;
					4'h1: src_data = snap_time.seconds;
					4'h2: src_data = snap_time.picoseconds[63:32];
					4'h3: src_data = snap_time.picoseconds[31:0];
					default: begin
						src_data[dcp_pkg::IND_CHANGE] = snap_change;
						src_data[dcp_pkg::IND_BANDWIDTH] = present.bandwidth;
						src_data[dcp_pkg::IND_FREQ_OFFSET] = present.freq_offset;
						src_data[dcp_pkg::IND_REF_LEVEL] = present.ref_level;
						src_data[dcp_pkg::IND_GEO] = present.geo;
						src_last = !(|present);
					end
				endcase
			end
			ST_BW: begin
				// upper word first, keeping the 64-bit value big-endian
				src_data = idx[0] ? snap.bandwidth[31:0] : snap.bandwidth[63:32];
				src_last = idx[0] && !present.freq_offset && !present.ref_level
					&& !present.geo;
			end
			ST_FO: begin
				src_data = idx[0] ? snap.freq_offset[31:0] : snap.freq_offset[63:32];
				src_last = idx[0] && !present.ref_level && !present.geo;
			end
			ST_RL: begin
				src_data = {16'h0000, snap.ref_level};
				src_last = !present.geo;
			end
			ST_GEO: begin
				src_data = snap.geo[(dcp_pkg::GEO_LAST - idx) * 32 +: 32];
				src_last = idx == dcp_pkg::GEO_LAST;
			end
		endcase
	end

	// ----------------------------------------
	// output buffer
	// ----------------------------------------
	dcp_skid #(
		.WIDTH(33)
	) u_skid (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.in_data({src_data, src_last}),
		.out_valid(word_valid),
		.out_ready(word_ready),
		.out_data({word_data, word_last})
	);
endmodule // dcp_builder
`default_nettype wire

// *** inc/dcp_pkg.sv ***
// digitizer context packet builder: shared constants and carrier types
// assumes a single 200 MHz clock domain; no bus, all controls are ports
// Operation
// - header packet type field is 0100
// - class flag clear, no class word
// - reserved header bits driven 00
// - timestamp mode bit is 0
// - integer timestamp type field is 01
// - fractional timestamp type field is 10
// - four-bit packet count, wraps after 1111
// - size field counts whole packet
// - stream identifier word 0x90000002 follows header
// - seconds, two picosecond words, indicator, in order
// - seconds counted since 1970 epoch
// - picoseconds since last seconds advance
// - presence bits 29, 26, 24, 14
// - fields in bit order: 2,2,1,11 words
// - bit 31 marks change, changed fields present
// - packet with change bit clear allowed
// - bandwidth 64-bit, point right of bit 20
// - frequency offset 64-bit, point right of bit 20
// - words big-endian, msb first
// - size field in 32-bit words
// - reference level upper half zero, q7 format
`default_nettype none
package dcp_pkg;

	// ----------------------------------------
	// header fields
	// ----------------------------------------
	localparam logic [3:0] PKT_TYPE_CONTEXT = 4'h4;
	localparam logic [0:0] CLASS_FLAG = 1'h0;
	localparam logic [1:0] RESERVED_BITS = 2'h0;
	localparam logic [0:0] TS_MODE = 1'h0;
	localparam logic [1:0] TS_INT_UTC = 2'h1;
	localparam logic [1:0] TS_FRAC_PS = 2'h2;
	localparam logic [3:0] PKT_COUNT_RESET = 4'h0;
	localparam logic [31:0] STREAM_ID = 32'h90000002;

	// ----------------------------------------
	// indicator positions and field lengths in words
	// ----------------------------------------
	localparam int IND_CHANGE = 31;
	localparam int IND_BANDWIDTH = 29;
	localparam int IND_FREQ_OFFSET = 26;
	localparam int IND_REF_LEVEL = 24;
	localparam int IND_GEO = 14;
	localparam logic [15:0] PREFIX_WORDS = 16'h0006;
	localparam logic [15:0] BW_WORDS = 16'h0002;
	localparam logic [15:0] FO_WORDS = 16'h0002;
	localparam logic [15:0] RL_WORDS = 16'h0001;
	localparam logic [15:0] GEO_WORDS = 16'h000b;
	localparam logic [3:0] GEO_LAST = 4'ha;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [63:0] bandwidth;
		logic [63:0] freq_offset;
		logic [15:0] ref_level;
		logic [351:0] geo;
	} dcp_fields_type;

	typedef struct packed {
		logic bandwidth;
		logic freq_offset;
		logic ref_level;
		logic geo;
	} dcp_present_type;

	typedef struct packed {
		logic [31:0] seconds;
		logic [63:0] picoseconds;
	} dcp_time_type;

	typedef struct packed {
		logic [31:0] data;
		logic last;
	} dcp_word_type;

endpackage
`default_nettype wire

// *** logic/dcp_skid.sv ***
// two-entry skid buffer for packet words
// assumes source and sink share clk_sys
`timescale 1ns/1ps
`default_nettype none
module dcp_skid #(
	parameter int WIDTH = 33
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] spare;
	logic spare_full;

	// ready is registered so the source never sees a combinational path
	assign in_ready = ~spare_full;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
			spare_full <= 1'b0;
			spare <= '0;
		end else begin
			if (!out_valid || out_ready) begin
				if (spare_full) begin
					out_valid <= 1'b1;
					out_data <= spare;
					spare_full <= 1'b0;
				end else begin
					out_valid <= in_valid;
					out_data <= in_data;
				end
			end else if (in_valid && in_ready) begin
				spare <= in_data;
				spare_full <= 1'b1;
			end
		end
	end
endmodule // dcp_skid
`default_nettype wire

// *** logic/dcp_size.sv ***
// packet length from the presence flags
// pure combinational helper on the same clock
`timescale 1ns/1ps
`default_nettype none
module dcp_size (
	// presence
	input wire dcp_pkg::dcp_present_type present,
	// length in words
	output logic [15:0] words
);
	always_comb begin
		words = dcp_pkg::PREFIX_WORDS;
		if (present.bandwidth) words = 16'(words + dcp_pkg::BW_WORDS);
		if (present.freq_offset) words = 16'(words + dcp_pkg::FO_WORDS);
		if (present.ref_level) words = 16'(words + dcp_pkg::RL_WORDS);
		if (present.geo) words = 16'(words + dcp_pkg::GEO_WORDS);
	end
endmodule // dcp_size
`default_nettype wire

// *** bench/dcp_builder_asserts.sv ***
// checker for the context packet builder word stream
// sees only the builder's ports; bound to it at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dcp_builder_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// word stream
	input wire logic word_valid,
	input wire logic word_ready,
	input wire logic [31:0] word_data,
	input wire logic word_last
);
	// ----------------------------------------
	// word index, size and count of the last header taken
	// ----------------------------------------
	logic [15:0] idx;
	logic [15:0] size;
	logic [3:0] hcnt;
	logic seen;
	wire logic xfer = word_valid && word_ready;
	wire logic hdr = word_valid && idx == 16'h0;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			idx <= 16'h0;
		end else if (xfer) begin
			idx <= word_last ? 16'h0 : idx + 16'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			size <= 16'h0;
			hcnt <= 4'h0;
			seen <= 1'b0;
		end else if (xfer && idx == 16'h0) begin
			size <= word_data[15:0];
			hcnt <= word_data[19:16];
			seen <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_pkt_type: assert property (hdr |-> word_data[31:28] == 4'h4)
		else $error("header type field wrong");
	a_hdr_flags: assert property (hdr |-> word_data[27:24] == 4'h0)
		else $error("header flag bits not zero");
	a_ts_types: assert property (hdr |-> word_data[23:20] == 4'h6)
		else $error("timestamp type fields wrong");
	a_stream_id: assert property (word_valid && idx == 16'h1 |-> word_data == 32'h90000002)
		else $error("stream identifier wrong");
	a_size_match: assert property (xfer && word_last |-> idx + 16'h1 == size)
		else $error("size field differs from words sent");
	a_min_len: assert property (xfer && word_last |-> idx >= 16'h6)
		else $error("packet ends before its first field");
	a_first_count: assert property (hdr && !seen |-> word_data[19:16] == 4'h0)
		else $error("first packet count not zero");
	a_count_step: assert property (hdr && seen |-> word_data[19:16] == hcnt + 4'h1)
		else $error("packet count did not advance by one");
	// a stalled word must not change under the receiver
	a_word_hold: assert property (word_valid && !word_ready |=>
		word_valid && $stable(word_data) && $stable(word_last))
		else $error("word changed while stalled");
endmodule // dcp_builder_asserts
bind dcp_builder dcp_builder_asserts chk_u (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.word_valid(word_valid),
	.word_ready(word_ready),
	.word_data(word_data),
	.word_last(word_last)
);
`default_nettype wire

// *** bench/dcp_sink.sv ***
// host receiver model: takes packet words, optionally stalling
// assumes the builder's valid/ready word stream on clk_sys
`timescale 1ns/1ps
`default_nettype none
module dcp_sink (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// pacing: high stalls every other cycle
	input wire logic slow,
	// word stream
	input wire logic word_valid,
	output logic word_ready,
	input wire logic [31:0] word_data,
	input wire logic word_last
);
	// words kept as {data, last} for the bench to pop
	logic [32:0] q[$];
	int pkts;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			word_ready <= 1'b0;
			pkts <= 0;
		end else begin
			if (word_valid && word_ready) begin
				q.push_back({word_data, word_last});
				if (word_last) pkts <= pkts + 1;
			end
			word_ready <= slow ? !word_ready : 1'b1;
		end
	end
endmodule // dcp_sink
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the context packet builder
// assumes the host model in dcp_sink and the bound stream checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [63:0] bw;
		logic [63:0] fo;
		logic [15:0] rl;
		logic geo_en;
		logic [31:0] gb;
		logic [31:0] ind;
	} dcp_row_type;
	logic clk_sys, arst_n, geo_enable, report_req, slow, word_valid, word_ready, word_last, busy;
	logic [31:0] word_data;
	logic [3:0] pkt_count, exp_cnt;
	dcp_pkg::dcp_fields_type s, f0;
	dcp_pkg::dcp_time_type now;
	int fails, cmp_count, want;
	dcp_row_type rows[4] = '{
		'{64'h1e84_8000, 64'h0, 16'h0, 1'b0, 32'h0, 32'ha000_0000},
		'{64'h1e84_8000, 64'hffff_ffff_fff0_0000, 16'hff80, 1'b0, 32'h0, 32'h8500_0000},
		'{64'h1e84_8000, 64'hffff_ffff_fff0_0000, 16'hff80, 1'b1, 32'hc0de_0000, 32'h8000_4000},
		'{64'h2, 64'h3, 16'h0080, 1'b1, 32'hbeef_0000, 32'ha500_4000}};
	dcp_builder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .settings(s),
		.geo_enable(geo_enable), .now(now), .report_req(report_req),
		.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
		.word_last(word_last), .busy(busy), .pkt_count(pkt_count));
	dcp_sink snk_u (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data), .word_last(word_last));
	always #2.5 clk_sys = ~clk_sys;
	// ----------------------------------------
	// compare, wait, request and closing tasks
	// ----------------------------------------
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_pkts;
		want++;
		for (int i = 0; i < 3000 && snk_u.pkts < want; i++) @(posedge clk_sys);
		chk32("packets", want, snk_u.pkts);
		#1;
	endtask
	// expected words are built from the field snapshot the packet must carry
	task automatic check_pkt(input dcp_pkg::dcp_fields_type f, input logic [31:0] ind);
		logic [31:0] e[$];
		logic [32:0] w;
		e = {32'h0, 32'h90000002, now.seconds, now.picoseconds[63:32], now.picoseconds[31:0], ind};
		if (ind[29]) e = {e, f.bandwidth[63:32], f.bandwidth[31:0]};
		if (ind[26]) e = {e, f.freq_offset[63:32], f.freq_offset[31:0]};
		if (ind[24]) e.push_back({16'h0, f.ref_level});
		if (ind[14]) for (int i = 0; i < 11; i++) e.push_back(f.geo[351-32*i -: 32]);
		e[0] = {12'h406, exp_cnt, 16'(e.size())};
		foreach (e[i]) begin
			w = snk_u.q.pop_front();
			chk32("word", e[i], w[32:1]);
			chk32("last", 32'(i == e.size() - 1), 32'(w[0]));
		end
		exp_cnt++;
	endtask
	task automatic pulse;
		report_req = 1'b1;
		@(posedge clk_sys);
		#1 report_req = 1'b0;
	endtask
	initial begin
		#200000 fails++;
		conclude();
	end
	initial begin
		{clk_sys, arst_n, geo_enable, report_req, slow, fails, cmp_count, want} = '0;
		{s, exp_cnt} = '0;
		now = {32'h6502_1a40, 64'h0000_0123_4567_89ab};
		repeat (3) @(posedge clk_sys);
		#1 chk32("reset outputs", 32'h0, 32'({word_valid, busy, pkt_count}));
		arst_n = 1'b1;
		$display("reset done");
		foreach (rows[r]) begin
			@(posedge clk_sys);
			#1 {s.bandwidth, s.freq_offset, s.ref_level} = {rows[r].bw, rows[r].fo, rows[r].rl};
			for (int i = 0; i < 11; i++) s.geo[351-32*i -: 32] = rows[r].gb + i;
			geo_enable = rows[r].geo_en;
			wait_pkts();
			check_pkt(s, rows[r].ind);
			$display("row %0d done", r);
		end
		// report with nothing changed, receiver stalling, change while busy
		slow = 1'b1;
		f0 = s;
		pulse();
		repeat (3) @(posedge clk_sys);
		#1 s.ref_level = 16'h7fff;
		chk32("busy", 32'h1, 32'(busy));
		wait_pkts();
		check_pkt(f0, 32'h2500_4000);
		wait_pkts();
		check_pkt(s, 32'h8100_0000);
		$display("stalled report and late change done");
		slow = 1'b0;
		repeat (16) begin
			pulse();
			wait_pkts();
			check_pkt(s, 32'h2500_4000);
			chk32("pkt_count", 32'(exp_cnt), 32'(pkt_count));
			chk32("busy", 32'h0, 32'(busy));
		end
		$display("count wrap done");
		// full report with geolocation switched off carries no geolocation words
		geo_enable = 1'b0;
		pulse();
		wait_pkts();
		check_pkt(s, 32'h2500_0000);
		$display("report without geolocation done");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
